// File: rtl/dsx_defines.vh
`ifndef DSX_DEFINES_VH
`define DSX_DEFINES_VH

// Register byte offsets on the APB slave
`define DSX_OFF_CTRL    12'h000
`define DSX_OFF_BANKSEL 12'h004
`define DSX_OFF_FSP3    12'h008
`define DSX_OFF_WREG    12'h00c
`define DSX_OFF_FLAGS   12'h010
`define DSX_OFF_STATE   12'h014

// Field positions
`define DSX_CTRL_EXT    0
`define DSX_FLAGS_Z     0
`define DSX_FLAGS_N     1
`define DSX_STATE_SKIP  4
`define DSX_STATE_BUSY  5
`define DSX_STATE_IDX   6
`define DSX_STATE_EA_LO 16

// Reset values
`define DSX_RST_CTRL    1'b0
`define DSX_RST_BANKSEL 4'h0
`define DSX_RST_FSP3    12'h000
`define DSX_RST_WREG    8'h00

// Opcode fields: upper six bits of the instruction word
`define DSX_OP_DECSZ    6'h0b
`define DSX_OP_DECSNZ   6'h13
`define DSX_OP_XORFILE  6'h06
`define DSX_BIT_D       9
`define DSX_BIT_A       8

// Access bank split and upper access bank page
`define DSX_ACC_LIMIT   8'h5f
`define DSX_ACC_HIPAGE  4'hf

// Phases per instruction cycle
`define DSX_PHASES      4

`endif

// File: rtl/dsx_addr_resolve.v
`timescale 1ns/1ps
`default_nettype none
`include "dsx_defines.vh"

// Forms the data memory address of a file operand
module dsx_addr_resolve (
  input  wire [7:0]  fileOp,
  input  wire        accessSel,
  input  wire        extEnable,
  input  wire [3:0]  bankSel,
  input  wire [11:0] fsp3,
  output reg  [11:0] effAddr,
  output reg         indexed
);

  always @* begin
    indexed = 1'b0;
    if (accessSel) begin
      effAddr = {bankSel, fileOp};
    end else if (extEnable && (fileOp <= `DSX_ACC_LIMIT)) begin
      // Pointer plus offset; pointer zero gives the plain access bank
      effAddr = fsp3 + {4'h0, fileOp};
      indexed = 1'b1;
    end else if (fileOp <= `DSX_ACC_LIMIT) begin
      effAddr = {4'h0, fileOp};
    end else begin
      effAddr = {`DSX_ACC_HIPAGE, fileOp};
    end
  end

endmodule // dsx_addr_resolve

`default_nettype wire

// File: rtl/dsx_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "dsx_defines.vh"

module dsx_exec (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        instrValid,
  input  wire [15:0] instr,
  input  wire        instrTwoWord,
  output wire        instrReady,
  output reg  [11:0] dmAddr,
  output reg         dmRdEn,
  input  wire [7:0]  dmRdData,
  output reg         dmWrEn,
  output reg  [7:0]  dmWrData,
  output reg         slotSkipped,
  output reg         instrDone
);

  localparam [3:0] PH_Q1 = 4'h1;
  localparam [3:0] PH_Q2 = 4'h2;
  localparam [3:0] PH_Q3 = 4'h4;
  localparam [3:0] PH_Q4 = 4'h8;

  localparam [1:0] OP_NONE = 2'h0;
  localparam [1:0] OP_DSZ  = 2'h1;
  localparam [1:0] OP_DSNZ = 2'h2;
  localparam [1:0] OP_XOR  = 2'h3;

  reg  [3:0]  phase_q;
  reg  [3:0]  phase_d;
  reg         extEn_q;
  reg  [3:0]  bankSel_q;
  reg  [11:0] fsp3_q;
  reg  [7:0]  wreg_q;
  reg         flagN_q;
  reg         flagZ_q;
  reg  [1:0]  op_q;
  reg         dest_q;
  reg  [7:0]  operand_q;
  reg  [7:0]  result_q;
  reg         skipPend_q;
  reg         skipMore_q;
  reg  [11:0] lastEa_q;
  reg         lastIdx_q;
  wire [11:0] effAddr;
  wire        indexed;
  wire        take;
  wire        apbWr;
  wire        apbSetup;
  wire        hit;
  reg  [31:0] rdMux;

  function [1:0] decodeOp;
    input [15:0] word;
    begin
      case (word[15:10])
        `DSX_OP_DECSZ:  decodeOp = OP_DSZ;
        `DSX_OP_DECSNZ: decodeOp = OP_DSNZ;
        `DSX_OP_XORFILE: decodeOp = OP_XOR;
        default:        decodeOp = OP_NONE;
      endcase
    end
  endfunction

  function isMapped;
    input [11:0] addr;
    begin
      case (addr)
        `DSX_OFF_CTRL, `DSX_OFF_BANKSEL, `DSX_OFF_FSP3,
        `DSX_OFF_WREG, `DSX_OFF_FLAGS, `DSX_OFF_STATE: isMapped = 1'b1;
        default: isMapped = 1'b0;
      endcase
    end
  endfunction

  function [7:0] aluCompute;
    input [1:0] kind;
    input [7:0] work;
    input [7:0] opnd;
    begin
      case (kind)
        OP_DSZ, OP_DSNZ: aluCompute = opnd - 8'h01;
        OP_XOR:          aluCompute = work ^ opnd;
        default:         aluCompute = opnd;
      endcase
    end
  endfunction

  function skipTaken;
    input [1:0] kind;
    input [7:0] res;
    begin
      case (kind)
        OP_DSZ:  skipTaken = (res == 8'h00);
        OP_DSNZ: skipTaken = (res != 8'h00);
        default: skipTaken = 1'b0;
      endcase
    end
  endfunction

  // Operand address for any access-bit instruction in the slot
  dsx_addr_resolve uResolve (
    .fileOp    (instr[7:0]),
    .accessSel (instr[`DSX_BIT_A]),
    .extEnable (extEn_q),
    .bankSel   (bankSel_q),
    .fsp3      (fsp3_q),
    .effAddr   (effAddr),
    .indexed   (indexed)
  );

  // Zero-wait APB slave
  assign pready   = 1'b1;
  assign hit      = isMapped(paddr);
  assign apbWr    = psel & penable & pwrite & hit;
  assign apbSetup = psel & ~penable;
  assign pslverr  = psel & penable & ~hit;

  assign instrReady = phase_q[0];
  assign take       = phase_q[0] & instrValid;

  always @* begin
    case (phase_q)
      PH_Q1:   phase_d = PH_Q2;
      PH_Q2:   phase_d = PH_Q3;
      PH_Q3:   phase_d = PH_Q4;
      PH_Q4:   phase_d = PH_Q1;
      default: phase_d = PH_Q1;
    endcase
  end

  always @* begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `DSX_OFF_CTRL:    rdMux[`DSX_CTRL_EXT] = extEn_q;
      `DSX_OFF_BANKSEL: rdMux[3:0] = bankSel_q;
      `DSX_OFF_FSP3:    rdMux[11:0] = fsp3_q;
      `DSX_OFF_WREG:    rdMux[7:0] = wreg_q;
      `DSX_OFF_FLAGS: begin
        rdMux[`DSX_FLAGS_Z] = flagZ_q;
        rdMux[`DSX_FLAGS_N] = flagN_q;
      end
      `DSX_OFF_STATE: begin
        rdMux[3:0] = phase_q;
        rdMux[`DSX_STATE_SKIP] = skipPend_q;
        rdMux[`DSX_STATE_BUSY] = (op_q != OP_NONE);
        rdMux[`DSX_STATE_IDX] = lastIdx_q;
        rdMux[`DSX_STATE_EA_LO+11:`DSX_STATE_EA_LO] = lastEa_q;
      end
      default:          rdMux = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (apbSetup && !pwrite) begin
      prdata <= rdMux;
    end
  end

  // Software-owned control
  always @(posedge mclk) begin
    if (!rst_n) begin
      extEn_q   <= `DSX_RST_CTRL;
      bankSel_q <= `DSX_RST_BANKSEL;
      fsp3_q    <= `DSX_RST_FSP3;
    end else if (apbWr) begin
      if (paddr == `DSX_OFF_CTRL) begin
        extEn_q <= pwdata[`DSX_CTRL_EXT];
      end
      if (paddr == `DSX_OFF_BANKSEL) begin
        bankSel_q <= pwdata[3:0];
      end
      if (paddr == `DSX_OFF_FSP3) begin
        fsp3_q <= pwdata[11:0];
      end
    end
  end

  // Four-phase sequencer
  always @(posedge mclk) begin
    if (!rst_n) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Q1: decode; a slot under skip decodes to no operation
  always @(posedge mclk) begin
    if (!rst_n) begin
      op_q        <= OP_NONE;
      dest_q      <= 1'b0;
      dmAddr      <= 12'h000;
      dmRdEn      <= 1'b0;
      lastEa_q    <= 12'h000;
      lastIdx_q   <= 1'b0;
      slotSkipped <= 1'b0;
      skipMore_q  <= 1'b0;
    end else begin
      slotSkipped <= 1'b0;
      dmRdEn      <= 1'b0;
      if (phase_q[0]) begin
        op_q       <= OP_NONE;
        skipMore_q <= 1'b0;
        if (take && skipPend_q) begin
          slotSkipped <= 1'b1;
          skipMore_q  <= instrTwoWord & ~skipMore_q;
        end else if (take) begin
          op_q     <= decodeOp(instr);
          dest_q   <= instr[`DSX_BIT_D];
          dmAddr   <= effAddr;
          lastEa_q <= effAddr;
          lastIdx_q <= indexed;
          dmRdEn   <= (decodeOp(instr) != OP_NONE);
        end
      end
    end
  end

  // Q2 read, Q3 compute
  always @(posedge mclk) begin
    if (!rst_n) begin
      operand_q <= 8'h00;
      result_q  <= 8'h00;
      dmWrEn    <= 1'b0;
      dmWrData  <= 8'h00;
    end else begin
      dmWrEn <= 1'b0;
      if (phase_q[1] && op_q != OP_NONE) begin
        operand_q <= dmRdData;
      end
      if (phase_q[2]) begin
        if (op_q != OP_NONE) begin
          result_q <= aluCompute(op_q, wreg_q, operand_q);
          dmWrData <= aluCompute(op_q, wreg_q, operand_q);
        end
        dmWrEn <= (op_q != OP_NONE) & dest_q;
      end
    end
  end

  // Q4: write destination, flags and skip decision
  always @(posedge mclk) begin
    if (!rst_n) begin
      wreg_q     <= `DSX_RST_WREG;
      flagN_q    <= 1'b0;
      flagZ_q    <= 1'b0;
      skipPend_q <= 1'b0;
      instrDone  <= 1'b0;
    end else begin
      instrDone <= 1'b0;
      if (apbWr && paddr == `DSX_OFF_WREG) begin
        wreg_q <= pwdata[7:0];
      end
      if (apbWr && paddr == `DSX_OFF_FLAGS) begin
        flagZ_q <= pwdata[`DSX_FLAGS_Z];
        flagN_q <= pwdata[`DSX_FLAGS_N];
      end
      if (phase_q[0] && take && skipPend_q && !(instrTwoWord && !skipMore_q)) begin
        skipPend_q <= 1'b0;
      end
      if (phase_q[3] && op_q != OP_NONE) begin
        instrDone <= 1'b1;
        if (!dest_q) begin
          wreg_q <= result_q;
        end
        skipPend_q <= skipTaken(op_q, result_q);
        if (op_q == OP_XOR) begin
          flagZ_q <= (result_q == 8'h00);
          flagN_q <= result_q[7];
        end
      end
    end
  end

endmodule // dsx_exec

`default_nettype wire

// File: testbench/dsx_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsx_defines.vh"
module dsx_exec_assertions (
  input wire        mclk,
  input wire        rst_n,
  input wire        instrValid,
  input wire [15:0] instr,
  input wire        instrReady,
  input wire [11:0] dmAddr,
  input wire        dmRdEn,
  input wire [7:0]  dmRdData,
  input wire        dmWrEn,
  input wire [7:0]  dmWrData,
  input wire        slotSkipped,
  input wire        instrDone
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_slot_len: assert property ($fell(instrReady) |-> !instrReady [*3] ##1 instrReady)
    else $error("bad slot length");
  a_dest_write: assert property (dmRdEn |-> ##2 dmWrEn == $past(instr[`DSX_BIT_D], 3))
    else $error("bad destination");
  a_dec_value: assert property (dmWrEn && $past(instr[15:10], 3) != `DSX_OP_XORFILE
    |-> dmWrData == $past(dmRdData, 2) - 8'h01) else $error("bad decrement");
  a_done_late: assert property (dmRdEn |-> ##3 instrDone) else $error("bad done");
  a_skip_zero: assert property (dmRdEn && $past(instr[15:10]) == `DSX_OP_DECSZ
    && dmRdData == 8'h01 ##3 instrValid |-> ##1 slotSkipped) else $error("no skip");
  a_keep_zero: assert property (dmRdEn && $past(instr[15:10]) == `DSX_OP_DECSZ
    && dmRdData != 8'h01 |-> ##4 !slotSkipped) else $error("bad skip");
  a_skip_nz: assert property (dmRdEn && $past(instr[15:10]) == `DSX_OP_DECSNZ
    && dmRdData != 8'h01 ##3 instrValid |-> ##1 slotSkipped) else $error("no skip");
  a_bank_addr: assert property ($past(instrValid && instrReady) && $past(instr[8])
    |-> slotSkipped || dmAddr[7:0] == $past(instr[7:0])) else $error("bad bank address");
  a_high_page: assert property ($past(instrValid && instrReady) && !$past(instr[8])
    && $past(instr[7:0]) > 8'h5f |-> slotSkipped || dmAddr == {4'hf, $past(instr[7:0])})
    else $error("bad access address");
  cover property (slotSkipped);
  cover property (dmWrEn);
  cover property (instrDone ##4 instrDone);
endmodule // dsx_exec_assertions
bind dsx_exec dsx_exec_assertions i_chk (.mclk, .rst_n, .instrValid, .instr, .instrReady,
  .dmAddr, .dmRdEn, .dmRdData, .dmWrEn, .dmWrData, .slotSkipped, .instrDone);
`default_nettype wire

// File: testbench/dsx_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsx_defines.vh"
module dsx_exec_tb;
  logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        instrValid = 0, instrTwoWord = 0, ext = 0, refZ = 0, refN = 0;
  logic [11:0] paddr = 0, ptr = 0;
  logic [31:0] pwdata = 0;
  logic [15:0] instr = 0;
  logic [3:0]  bank = 0;
  logic [7:0]  refW = 0;
  logic [7:0]  mem [4096];
  logic [7:0]  refMem [4096];
  logic [19:0] expW [$];
  logic [32:0] expR [$];
  int          failures = 0, total_checks = 0, skips = 0, expSkips = 0, cyc = 0, skipN = 0;
  wire [31:0]  prdata;
  wire [11:0]  dmAddr;
  wire [7:0]   dmWrData, dmRdData;
  wire         pready, pslverr, instrReady, dmRdEn, dmWrEn, slotSkipped, instrDone;
  // Data bus shows inverse outside the read pulse
  assign dmRdData = dmRdEn ? mem[dmAddr] : ~mem[dmAddr];
  always #4 mclk = ~mclk;
  dsx_exec i_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .instrValid, .instr, .instrTwoWord, .instrReady, .dmAddr, .dmRdEn, .dmRdData,
    .dmWrEn, .dmWrData, .slotSkipped, .instrDone);
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rst_n && dmWrEn === 1'b1) begin
      mem[dmAddr] <= dmWrData;
      cmp({dmAddr, dmWrData}, expW.size() ? expW.pop_front() : 'x);
    end
    if (psel && penable && pready && !pwrite)
      cmp({pslverr, prdata}, expR.size() ? expR.pop_front() : 'x);
    if (slotSkipped === 1'b1)
      skips++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expR.push_back(e);
    apb(0, a, 0);
  endtask
  // Word set after one Q1 is taken in the next slot
  task automatic slot(input logic v, input logic [15:0] w, input logic two);
    do @(negedge mclk); while (instrReady !== 1'b1);
    @(posedge mclk);
    instrValid <= v;
    instr <= w;
    instrTwoWord <= two;
  endtask
  function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
    if (a)
      return {bank, f};
    if (ext && f <= 8'h5f)
      return ptr + {4'h0, f};
    return {(f > 8'h5f) ? 4'hf : 4'h0, f};
  endfunction
  task automatic run(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f,
                     input logic two);
    logic [11:0] e;
    logic [7:0]  r;
    e = ea(a, f);
    if (skipN) begin
      skipN = 0;
      expSkips += 1 + two;
      slot(1, {op, d, a, f}, two);
      if (two)
        slot(1, 16'h0000, 0);
      return;
    end
    r = (op == `DSX_OP_XORFILE) ? refW ^ refMem[e] : refMem[e] - 8'h01;
    if (op != 6'h3f) begin
      if (d) begin
        refMem[e] = r;
        expW.push_back({e, r});
      end else
        refW = r;
      if (op == `DSX_OP_XORFILE) begin
        refZ = r == 0;
        refN = r[7];
      end
      skipN = (op == `DSX_OP_DECSZ && r == 0) || (op == `DSX_OP_DECSNZ && r != 0);
    end
    slot(1, {op, d, a, f}, 0);
  endtask
  task automatic idle();
    if (skipN)
      run(6'h3f, 0, 1, 8'h00, 0);
    repeat (3) slot(0, 16'h0000, 0);
  endtask
  initial begin
    logic [5:0]  ops [4];
    logic [31:0] rv;
    ops = '{`DSX_OP_DECSZ, `DSX_OP_DECSNZ, `DSX_OP_XORFILE, 6'h3f};
    void'($urandom(81101));
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'($urandom % 4);
      refMem[i] = mem[i];
    end
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    for (int i = 0; i < 5; i++)
      rd(12'(i * 4), 0);
    rd(12'h018, 33'h100000000);
    $display("reset test done");
    for (int k = 0; k < 3; k++) begin
      ext = k > 0;
      bank = 4'($urandom);
      ptr = (k == 1) ? 12'h000 : 12'($urandom);
      refW = 8'($urandom);
      apb(1, `DSX_OFF_CTRL, {31'h0, ext});
      apb(1, `DSX_OFF_BANKSEL, {28'h0, bank});
      apb(1, `DSX_OFF_FSP3, {20'h0, ptr});
      apb(1, `DSX_OFF_WREG, {24'h0, refW});
      for (int i = 0; i < 80; i++) begin
        rv = $urandom;
        run(ops[rv[1:0]], rv[2], rv[3], rv[11:4], rv[12]);
      end
      idle();
      rd(`DSX_OFF_WREG, {25'h0, refW});
      rd(`DSX_OFF_FLAGS, {31'h0, refN, refZ});
      $display("mode %0d test done", k);
    end
    cmp(skips, expSkips);
    cmp(expW.size(), 0);
    results();
  end
endmodule // dsx_exec_tb
`default_nettype wire
